// ---- rtl/trap_logic_instr_decode.sv ----
module trap_logic_instr_decode #(
  parameter int XLEN = decode_pkg::XLEN
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic instr_valid,
  input wire logic [31:0] instr_word,
  input wire logic [1:0] level_mode,
  input wire logic [XLEN-1:0] src_value,
  input wire logic [XLEN-1:0] tgt_value,
  input wire logic bus_idle,
  input wire logic wake,
  output logic instr_ready,
  output logic done,
  output logic trap_exc,
  output logic reserved_exc,
  output logic wr_en,
  output logic [4:0] wr_addr,
  output logic [XLEN-1:0] wr_data,
  output logic low_power_standby,
  output logic [27:0] jump_low
);
  typedef enum logic [1:0] {ST_RUN, ST_WAIT_IDLE, ST_STANDBY} state_e;

  decode_if dif ();
  field_decoder u_dec (.d(dif.dec));

  logic bus_idle_meta_reg;
  logic bus_idle_sync_reg;
  logic wake_meta_reg;
  logic wake_sync_reg;
  state_e state_reg;
  state_e state_next;
  logic ready_reg;
  logic standby_reg;
  logic done_reg;
  logic trap_reg;
  logic rsvd_reg;
  logic wr_en_reg;
  logic [4:0] wr_addr_reg;
  logic [XLEN-1:0] wr_data_reg;
  logic [27:0] jump_reg;

  // the whole aligned word feeds the decoder
  assign dif.instr = instr_word;
  assign dif.mode = level_mode;

  wire running = ready_reg;
  wire take = instr_valid && running;
  wire [XLEN-1:0] imm_sext = {{(XLEN-16){dif.imm[15]}}, dif.imm};
  wire [XLEN-1:0] imm_zext = {{(XLEN-16){1'b0}}, dif.imm};
  wire ltu_hit = src_value < tgt_value;
  wire ne_hit = src_value != tgt_value;
  wire nei_hit = src_value != imm_sext;
  wire is_trap_less_unsigned = dif.kind == decode_pkg::OP_TRAP_LESS_UNSIGNED;
  wire is_tne = dif.kind == decode_pkg::OP_TNE;
  wire is_trap_not_equal_imm = dif.kind == decode_pkg::OP_TRAP_NOT_EQUAL_IMM;
  wire is_xr = dif.kind == decode_pkg::OP_XOR_REG;
  wire is_xi = dif.kind == decode_pkg::OP_XOR_IMM;
  wire trap_hit = (is_trap_less_unsigned && ltu_hit) || (is_tne && ne_hit) || (is_trap_not_equal_imm && nei_hit);
  wire write_hit = is_xr || is_xi;
  wire [4:0] dest = is_xr ? dif.dst_reg_field : dif.tgt_reg_field;
  wire [XLEN-1:0] xor_val = src_value ^ (is_xr ? tgt_value : imm_zext);
  wire standby_req = take && dif.kind == decode_pkg::OP_STANDBY;

  // Standby waits for a quiet bus so no transfer is cut in half
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_RUN: if (standby_req) state_next = bus_idle_sync_reg ? ST_STANDBY : ST_WAIT_IDLE;
      ST_WAIT_IDLE: if (bus_idle_sync_reg) state_next = ST_STANDBY;
      ST_STANDBY: if (wake_sync_reg) state_next = ST_RUN;
      default: state_next = ST_RUN;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_idle_meta_reg <= 1'b0;
      bus_idle_sync_reg <= 1'b0;
      wake_meta_reg <= 1'b0;
      wake_sync_reg <= 1'b0;
    end else begin
      bus_idle_meta_reg <= bus_idle;
      bus_idle_sync_reg <= bus_idle_meta_reg;
      wake_meta_reg <= wake;
      wake_sync_reg <= wake_meta_reg;
    end
  end

  // Ready and standby flags are registered copies of the next state so the pins come from flip-flops
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_RUN;
      ready_reg <= 1'b1;
      standby_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      ready_reg <= state_next == ST_RUN;
      standby_reg <= state_next == ST_STANDBY;
    end
  end

  // Outside ST_RUN nothing is taken, so done, trap, reserved and write-enable flags clear; write address, data and jump registers hold
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      done_reg <= 1'b0;
      trap_reg <= 1'b0;
      rsvd_reg <= 1'b0;
      wr_en_reg <= 1'b0;
      wr_addr_reg <= 5'h00;
      wr_data_reg <= '0;
      jump_reg <= 28'h0000000;
    end else begin
      done_reg <= take;
      trap_reg <= take && trap_hit;
      rsvd_reg <= take && dif.kind == decode_pkg::OP_RSVD;
      wr_en_reg <= take && write_hit;
      if (take && write_hit) begin
        wr_addr_reg <= dest;
        wr_data_reg <= xor_val;
      end
      if (take) jump_reg <= dif.jump_low;
    end
  end

  assign instr_ready = ready_reg;
  assign done = done_reg;
  assign trap_exc = trap_reg;
  assign reserved_exc = rsvd_reg;
  assign wr_en = wr_en_reg;
  assign wr_addr = wr_addr_reg;
  assign wr_data = wr_data_reg;
  assign low_power_standby = standby_reg;
  assign jump_low = jump_reg;
endmodule

// ---- shared/decode_pkg.sv ----
package decode_pkg;
  localparam int XLEN = 64;
  localparam int IW = 32;
  // Field positions
  localparam int OPC_HI = 31;
  localparam int OPC_LO = 26;
  localparam int SRC_HI = 25;
  localparam int SRC_LO = 21;
  localparam int TGT_HI = 20;
  localparam int TGT_LO = 16;
  localparam int DST_HI = 15;
  localparam int DST_LO = 11;
  localparam int SHAMT_HI = 10;
  localparam int SHAMT_LO = 6;
  localparam int FUNC_HI = 5;
  localparam int FUNC_LO = 0;
  localparam int IMM_HI = 15;
  localparam int IMM_LO = 0;
  localparam int JIDX_HI = 25;
  localparam int JIDX_LO = 0;
  localparam int CODE_HI = 15;
  localparam int CODE_LO = 6;
  localparam int COP_BIT = 25;
  localparam int COPZ_HI = 24;
  localparam int COPZ_LO = 6;
  localparam int JTGT_W = 28;
  localparam int JSHIFT = 2;
  // Primary opcodes
  localparam logic [5:0] reg_class_opcode = 6'h00;
  localparam logic [5:0] reg_imm_class_opcode = 6'h01;
  localparam logic [5:0] OPC_XOR_IMM = 6'h0E;
  localparam logic [5:0] system_coproc_class = 6'h10;
  localparam logic [5:0] OPC_COP3 = 6'h13;
  localparam logic [5:0] OPC_LWC3 = 6'h33;
  localparam logic [5:0] OPC_LDC3 = 6'h37;
  localparam logic [5:0] OPC_SWC3 = 6'h3B;
  localparam logic [5:0] OPC_SDC3 = 6'h3F;
  // Function codes
  localparam logic [5:0] FN_XOR = 6'h26;
  localparam logic [5:0] FN_TRAP_LESS_UNSIGNED = 6'h33;
  localparam logic [5:0] FN_TNE = 6'h36;
  localparam logic [5:0] FN_STANDBY = 6'h20;
  // Target-field codes under the reg-imm class
  localparam logic [4:0] RT_TRAP_NOT_EQUAL_IMM = 5'h0E;

  typedef enum logic [1:0] {LEVEL_FULL, LEVEL_II_ONLY, LEVEL_III_ONLY} level_mode_e;
  typedef enum logic [2:0] {OP_NONE, OP_TRAP_LESS_UNSIGNED, OP_TNE, OP_TRAP_NOT_EQUAL_IMM, OP_STANDBY, OP_XOR_REG, OP_XOR_IMM, OP_RSVD} op_kind_e;
endpackage

// ---- shared/decode_if.sv ----
interface decode_if;
  logic [31:0] instr;
  logic [1:0] mode;
  decode_pkg::op_kind_e kind;
  logic [4:0] src_reg_field;
  logic [4:0] tgt_reg_field;
  logic [4:0] dst_reg_field;
  logic [4:0] shift_amount_field;
  logic [15:0] imm;
  logic [27:0] jump_low;
  modport dec (input instr, input mode, output kind, output src_reg_field, output tgt_reg_field,
    output dst_reg_field, output shift_amount_field, output imm, output jump_low);
  modport core (output instr, output mode, input kind, input src_reg_field, input tgt_reg_field,
    input dst_reg_field, input shift_amount_field, input imm, input jump_low);
endinterface

// ---- rtl/field_decoder.sv ----
module field_decoder (
  decode_if.dec d
);
  wire [5:0] opc = d.instr[decode_pkg::OPC_HI:decode_pkg::OPC_LO];
  wire [5:0] fn = d.instr[decode_pkg::FUNC_HI:decode_pkg::FUNC_LO];
  wire [4:0] rt = d.instr[decode_pkg::TGT_HI:decode_pkg::TGT_LO];
  wire shamt_zero = d.instr[decode_pkg::SHAMT_HI:decode_pkg::SHAMT_LO] == 5'h00;
  wire copz_zero = d.instr[decode_pkg::COPZ_HI:decode_pkg::COPZ_LO] == 19'h00000;
  wire cop3_enc = (opc == decode_pkg::OPC_COP3) || (opc == decode_pkg::OPC_LWC3) ||
    (opc == decode_pkg::OPC_LDC3) || (opc == decode_pkg::OPC_SWC3) || (opc == decode_pkg::OPC_SDC3);
  wire ii_only = d.mode == 2'(decode_pkg::LEVEL_II_ONLY);

  assign d.src_reg_field = d.instr[decode_pkg::SRC_HI:decode_pkg::SRC_LO];
  assign d.tgt_reg_field = rt;
  assign d.imm = d.instr[decode_pkg::IMM_HI:decode_pkg::IMM_LO];
  assign d.dst_reg_field = d.instr[decode_pkg::DST_HI:decode_pkg::DST_LO];
  assign d.shift_amount_field = d.instr[decode_pkg::SHAMT_HI:decode_pkg::SHAMT_LO];
  assign d.jump_low = {d.instr[decode_pkg::JIDX_HI:decode_pkg::JIDX_LO], {decode_pkg::JSHIFT{1'b0}}};

  // Opcode first, then function or target field by class; code field is not looked at for the two reg-class traps
  always_comb begin
    d.kind = decode_pkg::OP_NONE;
    case (opc)
      decode_pkg::reg_class_opcode: begin
        if (fn == decode_pkg::FN_TRAP_LESS_UNSIGNED) d.kind = decode_pkg::OP_TRAP_LESS_UNSIGNED;
        else if (fn == decode_pkg::FN_TNE) d.kind = decode_pkg::OP_TNE;
        else if (fn == decode_pkg::FN_XOR && shamt_zero) d.kind = decode_pkg::OP_XOR_REG;
      end
      decode_pkg::reg_imm_class_opcode: begin
        if (rt == decode_pkg::RT_TRAP_NOT_EQUAL_IMM) d.kind = decode_pkg::OP_TRAP_NOT_EQUAL_IMM;
      end
      decode_pkg::OPC_XOR_IMM: d.kind = decode_pkg::OP_XOR_IMM;
      decode_pkg::system_coproc_class: begin
        if (d.instr[decode_pkg::COP_BIT] && copz_zero && fn == decode_pkg::FN_STANDBY)
          d.kind = decode_pkg::OP_STANDBY;
      end
      default: begin
        // Level II only mode refuses coprocessor 3 encodings; other levels drop them
        if (cop3_enc && ii_only) d.kind = decode_pkg::OP_RSVD;
      end
    endcase
  end
endmodule

// ---- verif/trap_decode_asserts.sv ----
module trap_decode_asserts #(parameter int XLEN = 64) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic instr_valid,
  input wire logic [31:0] instr_word,
  input wire logic [1:0] level_mode,
  input wire logic [XLEN-1:0] src_value,
  input wire logic [XLEN-1:0] tgt_value,
  input wire logic instr_ready,
  input wire logic trap_exc,
  input wire logic reserved_exc,
  input wire logic wr_en,
  input wire logic [4:0] wr_addr,
  input wire logic [XLEN-1:0] wr_data,
  input wire logic low_power_standby,
  input wire logic [27:0] jump_low
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  wire take = instr_valid && instr_ready;
  wire [5:0] opc = instr_word[31:26];
  wire [5:0] fn = instr_word[5:0];
  wire rcls = take && opc == decode_pkg::reg_class_opcode;
  wire [4:0] dst = instr_word[15:11];
  wire [4:0] tgt = instr_word[20:16];
  wire [25:0] jidx = instr_word[25:0];
  wire [XLEN-1:0] simm = {{(XLEN-16){instr_word[15]}}, instr_word[15:0]};
  wire [XLEN-1:0] zimm = {{(XLEN-16){1'b0}}, instr_word[15:0]};
  sequence s_xreg; rcls && fn == decode_pkg::FN_XOR && instr_word[10:6] == 5'h00; endsequence
  sequence s_ximm; take && opc == decode_pkg::OPC_XOR_IMM; endsequence
  a_trap_below: assert property (
    rcls && fn == decode_pkg::FN_TRAP_LESS_UNSIGNED |=> trap_exc == ($past(src_value) < $past(tgt_value))) else $error("trap_less_unsigned bad");
  a_trap_differ: assert property (
    rcls && fn == decode_pkg::FN_TNE |=> trap_exc == ($past(src_value) != $past(tgt_value))) else $error("tne bad");
  a_trap_imm: assert property (
    take && opc == decode_pkg::reg_imm_class_opcode && tgt == decode_pkg::RT_TRAP_NOT_EQUAL_IMM
    |=> trap_exc == ($past(src_value) != $past(simm))) else $error("trap_not_equal_imm bad");
  a_xor_reg: assert property (s_xreg |=> wr_en && !trap_exc && wr_addr == $past(dst)
    && wr_data == ($past(src_value) ^ $past(tgt_value))) else $error("xor reg bad");
  a_xor_imm: assert property (s_ximm |=> wr_en && !trap_exc && wr_addr == $past(tgt)
    && wr_data == ($past(src_value) ^ $past(zimm))) else $error("xor imm bad");
  a_jump_form: assert property (take |=> jump_low == {$past(jidx), 2'b00}) else $error("jump bad");
  a_rsvd_level: assert property (
    take && level_mode == 2'h1 && opc == decode_pkg::OPC_COP3 |=> reserved_exc) else $error("rsvd bad");
  a_standby_stall: assert property (low_power_standby |-> !instr_ready) else $error("standby bad");
endmodule

bind trap_logic_instr_decode trap_decode_asserts #(.XLEN(XLEN)) u_chk (.*);

// ---- verif/fetch_model.sv ----
module fetch_model (
  input wire logic ref_clk,
  input wire logic instr_ready,
  output logic instr_valid,
  output logic [31:0] instr_word
);
  timeunit 1ns;
  timeprecision 1ns;
  logic hung = 1'b0;
  initial begin
    instr_valid = 1'b0;
    instr_word = 32'h0;
  end
  // Word held until taken; afterwards the lines show a changed value, never the stale word
  task automatic issue(input logic [31:0] w);
    int n = 0;
    instr_valid <= 1'b1;
    instr_word <= w;
    do begin
      @(negedge ref_clk);
      n++;
    end while (!instr_ready && n < 40);
    hung = n >= 40;
    @(posedge ref_clk);
    instr_valid <= 1'b0;
    instr_word <= ~w;
  endtask
endmodule

// ---- verif/tb_top.sv ----
`define CHK(n, e, a) begin tests_run++; if ((a) !== (e)) begin mismatches++; \
  $display("wrong value %s expected %0h seen %0h", n, e, a); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [1:0] level_mode = 2'h0;
  logic [63:0] src_value = 64'h0;
  logic [63:0] tgt_value = 64'h0;
  logic bus_idle = 1'b0;
  logic wake = 1'b0;
  logic instr_valid, instr_ready, done, trap_exc, reserved_exc, wr_en, low_power_standby;
  logic [31:0] instr_word;
  logic [4:0] wr_addr;
  logic [63:0] wr_data;
  logic [27:0] jump_low;
  int mismatches = 0;
  int tests_run = 0;
  always #50 ref_clk = ~ref_clk;
  fetch_model FETCH (.ref_clk(ref_clk), .instr_ready(instr_ready), .instr_valid(instr_valid), .instr_word(instr_word));
  trap_logic_instr_decode DUT (.*);
  task automatic summarize();
    $display("compares %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  function automatic logic [31:0] rw(input logic [9:0] mid, input logic [5:0] fn);
    return {decode_pkg::reg_class_opcode, 5'h01, 5'h02, mid, fn};
  endfunction
  task automatic run(input logic [31:0] w, input logic [63:0] s, t, input logic [2:0] ex);
    @(posedge ref_clk);
    src_value <= s;
    tgt_value <= t;
    FETCH.issue(w);
    if (FETCH.hung) begin
      mismatches++;
      summarize();
    end
    @(negedge ref_clk);
    `CHK("done", 1'b1, done)
    `CHK("trap", ex[2], trap_exc)
    `CHK("wr_en", ex[1], wr_en)
    `CHK("rsvd", ex[0], reserved_exc)
  endtask
  task automatic t_traps();
    run(rw(10'h3FF, decode_pkg::FN_TRAP_LESS_UNSIGNED), 64'h1, '1, 3'b100);
    run(rw(10'h155, decode_pkg::FN_TRAP_LESS_UNSIGNED), '1, 64'h1, 3'b000);
    run(rw(10'h2AA, decode_pkg::FN_TNE), 64'h5, 64'h4, 3'b100);
    run(rw(10'h000, decode_pkg::FN_TNE), 64'h5, 64'h5, 3'b000);
    run({decode_pkg::reg_imm_class_opcode, 5'h01, decode_pkg::RT_TRAP_NOT_EQUAL_IMM, 16'hFFFF}, '1, 64'h0, 3'b000);
    run({decode_pkg::reg_imm_class_opcode, 5'h01, decode_pkg::RT_TRAP_NOT_EQUAL_IMM, 16'hFFFF}, 64'hFFFF, 64'h0, 3'b100);
    $display("test traps done");
  endtask
  task automatic t_xor();
    run(rw({5'h07, 5'h00}, decode_pkg::FN_XOR), 64'hF0F0, 64'hFF00, 3'b010);
    `CHK("wr_addr", 5'h07, wr_addr)
    `CHK("wr_data", 64'h0FF0, wr_data)
    run({decode_pkg::OPC_XOR_IMM, 5'h01, 5'h09, 16'h8001}, 64'hFFFF000000000001, 64'h0, 3'b010);
    `CHK("wr_addr", 5'h09, wr_addr)
    `CHK("wr_data", 64'hFFFF000000008000, wr_data)
    `CHK("jump_low", 28'h0A60004, jump_low)
    @(posedge ref_clk);
    level_mode <= 2'h1;
    run({decode_pkg::OPC_COP3, 26'h0}, 64'h0, 64'h0, 3'b001);
    run({decode_pkg::OPC_SDC3, 26'h0}, 64'h0, 64'h0, 3'b001);
    @(posedge ref_clk);
    level_mode <= 2'h0;
    run(rw(10'h0, decode_pkg::FN_TNE), 64'h1, 64'h2, 3'b100);
    $display("test xor and levels done");
  endtask
  task automatic t_standby();
    int n = 0;
    run({decode_pkg::system_coproc_class, 1'b1, 19'h0, decode_pkg::FN_STANDBY}, 64'h0, 64'h0, 3'b000);
    repeat (5) @(negedge ref_clk);
    `CHK("standby", 1'b0, low_power_standby)
    @(posedge ref_clk);
    bus_idle <= 1'b1;
    while (low_power_standby !== 1'b1 && n < 10) begin
      @(negedge ref_clk);
      n++;
    end
    `CHK("standby", 1'b1, low_power_standby)
    @(posedge ref_clk);
    wake <= 1'b1;
    for (n = 0; instr_ready !== 1'b1 && n < 10; n++) @(negedge ref_clk);
    `CHK("ready", 1'b1, instr_ready)
    @(posedge ref_clk);
    wake <= 1'b0;
    $display("test standby done");
  endtask
  initial begin
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_traps();
    t_xor();
    t_standby();
    summarize();
  end
endmodule
